// file: include/sram_wmask_pkg.sv
// constants, types and helpers shared by the write-mask sram path
package sram_wmask_pkg;

  // ****************************************************************
  // sizes and reset values
  // ****************************************************************
  localparam int ADDR_W = 4;
  localparam int DATA_W = 36;
  localparam int SEL_W = 4;
  localparam int FIFO_DEPTH = 16;
  localparam int LANE_WIDE_W = 9;
  localparam int LANE_NARROW_W = 4;
  localparam int WORDS = 2 ** (ADDR_W + 1);
  localparam logic BEAT_FIRST = 1'h0;
  localparam logic BEAT_SECOND = 1'h1;
  localparam logic OE_RESET = 1'h0;
  localparam logic MODE_RESET = 1'h0;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {ORG_X8, ORG_X9, ORG_X18, ORG_X36} org_t;
  typedef logic [DATA_W-1:0] word_t;
  typedef logic [SEL_W-1:0] sel_t;
  typedef logic [ADDR_W-1:0] addr_t;

  localparam word_t WORD_RESET = 36'h0;
  localparam addr_t ADDR_RESET = 4'h0;

  // one write burst as it travels from capture to the array
  typedef struct packed {
    addr_t addr;
    word_t data0;
    word_t data1;
    word_t mask0;
    word_t mask1;
  } wr_entry_t;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // expand active-low lane selects into a per-bit write mask
  function automatic word_t lane_mask(org_t org, sel_t sel_n);
    word_t m;
    int lanes;
    int lw;
    m = '0;
    lanes = (org == ORG_X36) ? 4 : (org == ORG_X9) ? 1 : 2;
    lw = (org == ORG_X8) ? LANE_NARROW_W : LANE_WIDE_W;
    for (int i = 0; i < SEL_W; i++) begin
      if (i < lanes) begin
        for (int b = 0; b < LANE_WIDE_W; b++) begin
          if (b < lw) begin
            m[i * lw + b] = ~sel_n[i];
          end
        end
      end
    end
    return m;
  endfunction : lane_mask

  // selected bits take new data, the rest keep the old word
  function automatic word_t merge(word_t old, word_t data, word_t mask);
    return (old & ~mask) | (data & mask);
  endfunction : merge

endpackage : sram_wmask_pkg

// file: core/wr_fifo.sv
// first-in first-out buffer for captured write bursts
`timescale 1ns/1ps

module wr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PTR_W-1:0] wr_ptr_q;
  logic [PTR_W-1:0] rd_ptr_q;
  logic [PTR_W:0] count_q;
  logic push;
  logic pop;

  // honest full and empty from the occupancy count
  assign in_ready = (count_q != DEPTH[PTR_W:0]);
  assign out_valid = (count_q != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_q[rd_ptr_q];

  // storage, written only on a push
  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  // pointers and count
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= PTR_W'(wr_ptr_q + 1'b1);
      end
      if (pop) begin
        rd_ptr_q <= PTR_W'(rd_ptr_q + 1'b1);
      end
      if (push && !pop) begin
        count_q <= (PTR_W + 1)'(count_q + 1'b1);
      end else if (pop && !push) begin
        count_q <= (PTR_W + 1)'(count_q - 1'b1);
      end
    end
  end

endmodule : wr_fifo

// file: core/ddr_sio_sram_byte_write_mask.sv
// write-mask and burst path of a separate-io double-rate burst-of-two sram
// How it works
// R1 - two selects gate lower and upper lanes
// R2 - all selects high leaves word unchanged
// R3 - nine-bit part: one select, whole word
// R4 - 36-bit: four selects, four nine-bit lanes
// R5 - only select 0 writes bits 8:0
// R6 - each beat uses its own mask
// R7 - power-up deselected, read outputs released
// R8 - one write beat per input clock edge
// R9 - read data on output clocks, else input
// R10 - burst reads A then A plus one
// R11 - data counted in cycles after issue
// R12 - controller parks clocks quietly when stopped
// R13 - write issue, data beats next cycle
// R14 - read issue, two words next cycle; the code drives them one cycle later, two edges after issue
// R15 - load high means no operation
// R16 - posted write commits on next write
`timescale 1ns/1ps

module ddr_sio_sram_byte_write_mask #(
  parameter sram_wmask_pkg::org_t ORG = sram_wmask_pkg::ORG_X36
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic load_strobe_n,
  input wire logic transfer_direction,
  input wire logic [sram_wmask_pkg::ADDR_W-1:0] address,
  input wire logic [sram_wmask_pkg::DATA_W-1:0] wr_data_k,
  input wire logic [sram_wmask_pkg::DATA_W-1:0] wr_data_kb,
  input wire logic [sram_wmask_pkg::SEL_W-1:0] byte_lane_write_select_n_k,
  input wire logic [sram_wmask_pkg::SEL_W-1:0] byte_lane_write_select_n_kb,
  input wire logic output_clocks_tied_high,
  output logic [sram_wmask_pkg::DATA_W-1:0] rd_data_first,
  output logic [sram_wmask_pkg::DATA_W-1:0] rd_data_second,
  output logic rd_data_oe,
  output logic use_input_clock,
  output logic write_ready
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  typedef enum logic [1:0] {ST_IDLE, ST_WRITE_DATA, ST_READ_DATA} phase_t;

  phase_t phase_q;
  phase_t phase_d;
  sram_wmask_pkg::addr_t wr_addr_q;
  sram_wmask_pkg::addr_t rd_addr_q;
  sram_wmask_pkg::word_t array_q [sram_wmask_pkg::WORDS];
  sram_wmask_pkg::wr_entry_t in_entry;
  sram_wmask_pkg::wr_entry_t head_entry;
  sram_wmask_pkg::wr_entry_t posted_q;
  logic posted_valid_q;
  logic fifo_in_valid;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic fifo_pop;
  logic issue_write;
  logic issue_read;
  logic strap_done_q;
  logic read_cycle;
  sram_wmask_pkg::word_t rd_word0;
  sram_wmask_pkg::word_t rd_word1;

  // ****************************************************************
  // command decode
  // ****************************************************************
  // R13 write issue decode
  assign issue_write = !load_strobe_n && !transfer_direction;
  // R14 read issue decode
  assign issue_read = !load_strobe_n && transfer_direction;

  // phase of the cycle after issue; a new command may overlap it
  always_comb begin
    phase_d = ST_IDLE;
    // R15 load high is a nop
    if (issue_write) begin
      phase_d = ST_WRITE_DATA;
    end else if (issue_read) begin
      phase_d = ST_READ_DATA;
    end
  end

  // R11 cycle t plus one
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= ST_IDLE;
    end else begin
      phase_q <= phase_d;
    end
  end

  // addresses latched at the issuing edge
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_addr_q <= sram_wmask_pkg::ADDR_RESET;
      rd_addr_q <= sram_wmask_pkg::ADDR_RESET;
    end else begin
      if (issue_write) begin
        wr_addr_q <= address;
      end
      if (issue_read) begin
        rd_addr_q <= address;
      end
    end
  end

  // ****************************************************************
  // write capture and buffering
  // ****************************************************************
  // R8 both beats captured in the data cycle
  assign fifo_in_valid = (phase_q == ST_WRITE_DATA);

  // R1 R3 R4 lane masks per organisation
  always_comb begin
    in_entry.addr = wr_addr_q;
    in_entry.data0 = wr_data_k;
    in_entry.data1 = wr_data_kb;
    // R6 separate mask per beat
    in_entry.mask0 = sram_wmask_pkg::lane_mask(ORG,
      byte_lane_write_select_n_k);
    in_entry.mask1 = sram_wmask_pkg::lane_mask(ORG,
      byte_lane_write_select_n_kb);
  end

  // the array port is busy on read cycles, so the buffer drains between
  assign read_cycle = (phase_q == ST_READ_DATA);
  assign fifo_out_ready = !read_cycle;
  assign fifo_pop = fifo_out_valid && fifo_out_ready;

  wr_fifo #(
    .WIDTH($bits(sram_wmask_pkg::wr_entry_t)),
    .DEPTH(sram_wmask_pkg::FIFO_DEPTH)
  ) u_wr_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .in_valid(fifo_in_valid),
    .in_ready(write_ready),
    .in_data(in_entry),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(head_entry)
  );

  // ****************************************************************
  // posted write and array
  // ****************************************************************
  // R16 hold the newest write until the next one
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      posted_valid_q <= 1'h0;
      posted_q <= '0;
    end else if (fifo_pop) begin
      posted_valid_q <= 1'h1;
      posted_q <= head_entry;
    end
  end

  // R16 older posted burst lands when a new one arrives
  // R2 R5 masked merge keeps unselected lanes
  always_ff @(posedge clock) begin
    if (fifo_pop && posted_valid_q) begin
      array_q[{posted_q.addr, sram_wmask_pkg::BEAT_FIRST}] <=
        sram_wmask_pkg::merge(
          array_q[{posted_q.addr, sram_wmask_pkg::BEAT_FIRST}],
          posted_q.data0, posted_q.mask0);
      array_q[{posted_q.addr, sram_wmask_pkg::BEAT_SECOND}] <=
        sram_wmask_pkg::merge(
          array_q[{posted_q.addr, sram_wmask_pkg::BEAT_SECOND}],
          posted_q.data1, posted_q.mask1);
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  // R10 word A first, then A plus one; R16 posted data wins
  always_comb begin
    rd_word0 = array_q[{rd_addr_q, sram_wmask_pkg::BEAT_FIRST}];
    rd_word1 = array_q[{rd_addr_q, sram_wmask_pkg::BEAT_SECOND}];
    if (posted_valid_q && posted_q.addr == rd_addr_q) begin
      rd_word0 = sram_wmask_pkg::merge(rd_word0, posted_q.data0,
        posted_q.mask0);
      rd_word1 = sram_wmask_pkg::merge(rd_word1, posted_q.data1,
        posted_q.mask1);
    end
  end

  // R14 both words launched after the read data cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_first <= sram_wmask_pkg::WORD_RESET;
      rd_data_second <= sram_wmask_pkg::WORD_RESET;
    end else if (read_cycle) begin
      rd_data_first <= rd_word0;
      rd_data_second <= rd_word1;
    end
  end

  // R7 R15 outputs released unless a burst is on the pins
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_oe <= sram_wmask_pkg::OE_RESET;
    end else begin
      rd_data_oe <= read_cycle;
    end
  end

  // ****************************************************************
  // output clock strap
  // ****************************************************************
  // R9 strap caught once at the first edge after reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      strap_done_q <= 1'h0;
      use_input_clock <= sram_wmask_pkg::MODE_RESET;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'h1;
      use_input_clock <= output_clocks_tied_high;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  a_nop_release: assert property ( // R15
    @(posedge clock) disable iff (!rst_n)
    load_strobe_n ##1 1'b1 |=> !rd_data_oe)
    else $error("outputs driven after a nop");

  a_read_drive: assert property ( // R14
    @(posedge clock) disable iff (!rst_n)
    issue_read |=> read_cycle ##1 rd_data_oe)
    else $error("read burst not driven two edges after issue");

  a_write_capture: assert property ( // R13
    @(posedge clock) disable iff (!rst_n)
    issue_write |=> fifo_in_valid && in_entry.addr == $past(address))
    else $error("write beats not captured in the cycle after issue");

  a_lane_first: assert property ( // R4
    @(posedge clock) disable iff (!rst_n)
    fifo_in_valid && ORG == sram_wmask_pkg::ORG_X36 |->
      in_entry.mask0 == {{9{~byte_lane_write_select_n_k[3]}},
      {9{~byte_lane_write_select_n_k[2]}},
      {9{~byte_lane_write_select_n_k[1]}},
      {9{~byte_lane_write_select_n_k[0]}}})
    else $error("first beat lane mask wrong");

  a_all_high: assert property ( // R2
    @(posedge clock) disable iff (!rst_n)
    fifo_in_valid && (&byte_lane_write_select_n_k) |->
      in_entry.mask0 == '0)
    else $error("write mask set with all selects high");

  a_lane_low_only: assert property ( // R5
    @(posedge clock) disable iff (!rst_n)
    fifo_in_valid && ORG == sram_wmask_pkg::ORG_X36 &&
      byte_lane_write_select_n_kb == 4'he |->
      in_entry.mask1 == 36'h0000001ff)
    else $error("select 0 alone must write bits 8 to 0 only");

  a_beat_mask: assert property ( // R6
    @(posedge clock) disable iff (!rst_n)
    fifo_in_valid && ORG == sram_wmask_pkg::ORG_X36 |->
      in_entry.mask1 == {{9{~byte_lane_write_select_n_kb[3]}},
      {9{~byte_lane_write_select_n_kb[2]}},
      {9{~byte_lane_write_select_n_kb[1]}},
      {9{~byte_lane_write_select_n_kb[0]}}})
    else $error("second beat did not use its own mask");

  a_two_lanes: assert property ( // R1
    @(posedge clock) disable iff (!rst_n)
    fifo_in_valid |->
      (ORG != sram_wmask_pkg::ORG_X18 || in_entry.mask1 ==
      {18'h0, {9{~byte_lane_write_select_n_kb[1]}},
      {9{~byte_lane_write_select_n_kb[0]}}}) &&
      (ORG != sram_wmask_pkg::ORG_X8 || in_entry.mask1 ==
      {28'h0, {4{~byte_lane_write_select_n_kb[1]}},
      {4{~byte_lane_write_select_n_kb[0]}}}))
    else $error("two-select lane mask wrong");

  a_nine_whole: assert property ( // R3
    @(posedge clock) disable iff (!rst_n)
    fifo_in_valid && ORG == sram_wmask_pkg::ORG_X9 |->
      in_entry.mask0 == {27'h0, {9{~byte_lane_write_select_n_k[0]}}})
    else $error("nine-bit select must cover bits 8 to 0");

  a_high_second: assert property ( // R2
    @(posedge clock) disable iff (!rst_n)
    fifo_in_valid && (&byte_lane_write_select_n_kb) |->
      in_entry.mask1 == '0)
    else $error("second beat mask set with all selects high");

  a_posted_hold: assert property ( // R16
    @(posedge clock) disable iff (!rst_n)
    fifo_pop |=> posted_valid_q && posted_q == $past(head_entry))
    else $error("popped write not held as posted");

  a_drain_stall: assert property ( // R16
    @(posedge clock) disable iff (!rst_n)
    read_cycle |-> !fifo_pop)
    else $error("array written during a read cycle");

  a_strap_stable: assert property ( // R9
    @(posedge clock) disable iff (!rst_n)
    strap_done_q |=> $stable(use_input_clock))
    else $error("clock mode changed during operation");

endmodule : ddr_sio_sram_byte_write_mask

// file: verification/ctrl_model.sv
// memory controller model driving commands, write beats and selects
`timescale 1ns/1ps

module ctrl_model (
  input wire logic clock,
  output logic load_strobe_n,
  output logic transfer_direction,
  output sram_wmask_pkg::addr_t address,
  output sram_wmask_pkg::word_t wr_data_k,
  output sram_wmask_pkg::word_t wr_data_kb,
  output sram_wmask_pkg::sel_t sel_k,
  output sram_wmask_pkg::sel_t sel_kb
);
  // ********
  // bus driving
  // ********
  sram_wmask_pkg::word_t pd0;
  sram_wmask_pkg::word_t pd1;
  sram_wmask_pkg::sel_t ps0;
  sram_wmask_pkg::sel_t ps1;
  logic pv;

  // quiet bus at time zero
  initial begin
    load_strobe_n = 1'h1;
    transfer_direction = 1'h0;
    address = '0;
    wr_data_k = '0;
    wr_data_kb = '0;
    sel_k = '1;
    sel_kb = '1;
    pv = 1'h0;
  end

  // beats of the last write go out one cycle after its issue
  task automatic beat();
    if (pv) begin
      wr_data_k <= pd0;
      wr_data_kb <= pd1;
      sel_k <= ps0;
      sel_kb <= ps1;
      pv = 1'h0;
    end else begin
      // released lines change, so stale data never looks valid
      wr_data_k <= ~wr_data_k;
      wr_data_kb <= wr_data_k;
      sel_k <= ~sel_k;
      sel_kb <= ~sel_kb;
    end
  endtask : beat

  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clock);
      beat();
      load_strobe_n <= 1'h1;
      transfer_direction <= 1'($urandom());
      address <= ~address;
    end
  endtask : idle

  // write issue, beats held for the following edge
  task automatic write_burst(input sram_wmask_pkg::addr_t a,
    input sram_wmask_pkg::word_t d0, input sram_wmask_pkg::word_t d1,
    input sram_wmask_pkg::sel_t s0, input sram_wmask_pkg::sel_t s1);
    @(posedge clock);
    beat();
    load_strobe_n <= 1'h0;
    transfer_direction <= 1'h0;
    address <= a;
    pd0 = d0;
    pd1 = d1;
    ps0 = s0;
    ps1 = s1;
    pv = 1'h1;
  endtask : write_burst

  // read issue, one cycle of command
  task automatic read_burst(input sram_wmask_pkg::addr_t a);
    @(posedge clock);
    beat();
    load_strobe_n <= 1'h0;
    transfer_direction <= 1'h1;
    address <= a;
  endtask : read_burst
endmodule : ctrl_model

// file: verification/tb.sv
// self-checking bench for the write-mask sram path
`timescale 1ns/1ps

module tb;
  logic clock;
  logic rst_n;
  logic ld_n;
  logic dir;
  sram_wmask_pkg::addr_t addr;
  sram_wmask_pkg::word_t dk;
  sram_wmask_pkg::word_t dkb;
  sram_wmask_pkg::sel_t sk;
  sram_wmask_pkg::sel_t skb;
  wire [3:0][sram_wmask_pkg::DATA_W-1:0] rd_first;
  wire [3:0][sram_wmask_pkg::DATA_W-1:0] rd_second;
  wire [3:0] oe;
  wire [3:0] use_k;
  wire [3:0] wr_rdy;
  logic strap;
  logic [1:0] rd_pipe;
  sram_wmask_pkg::word_t mem [4][16][2];
  sram_wmask_pkg::word_t ob;
  int addr_q [$];
  int ra;
  sram_wmask_pkg::sel_t tbl [6] = '{4'hf, 4'he, 4'hd, 4'hb, 4'h7, 4'h0};
  int err_count;
  int n_compared;

  // ********
  // design and controller
  // ********
  ctrl_model m (.clock(clock), .load_strobe_n(ld_n),
    .transfer_direction(dir), .address(addr), .wr_data_k(dk),
    .wr_data_kb(dkb), .sel_k(sk), .sel_kb(skb));

  // every organisation sees the same command stream
  for (genvar g = 0; g < 4; g++) begin : g_org
    ddr_sio_sram_byte_write_mask #(
      .ORG(sram_wmask_pkg::org_t'(g))
    ) uut (
      .clock(clock), .rst_n(rst_n), .load_strobe_n(ld_n),
      .transfer_direction(dir), .address(addr), .wr_data_k(dk),
      .wr_data_kb(dkb), .byte_lane_write_select_n_k(sk),
      .byte_lane_write_select_n_kb(skb),
      .output_clocks_tied_high(strap), .rd_data_first(rd_first[g]),
      .rd_data_second(rd_second[g]), .rd_data_oe(oe[g]),
      .use_input_clock(use_k[g]), .write_ready(wr_rdy[g]));
  end

  initial begin
    clock = 1'h0;
    forever #10 clock = ~clock;
  end

  // ********
  // helpers
  // ********
  task automatic check(input sram_wmask_pkg::word_t seen,
    input sram_wmask_pkg::word_t exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic sram_wmask_pkg::word_t obits(input int g);
    return (g == 0) ? 36'h0000000ff : (g == 1) ? 36'h0000001ff :
      (g == 2) ? 36'h00003ffff : 36'hfffffffff;
  endfunction : obits

  // lanes of 4 or 9 bits, low select takes new data
  function automatic sram_wmask_pkg::word_t upd(input int g,
    sram_wmask_pkg::word_t old, sram_wmask_pkg::word_t d,
    sram_wmask_pkg::sel_t s);
    sram_wmask_pkg::word_t k;
    for (int i = 0; i < 36; i++) begin
      k[i] = (g == 0) ? ~s[(i / 4) % 4] : (g == 1) ? ~s[0] : ~s[i / 9];
    end
    k = k & obits(g);
    return (old & ~k) | (d & k);
  endfunction : upd

  task automatic wr(input int a, input sram_wmask_pkg::sel_t s0,
    input sram_wmask_pkg::sel_t s1);
    sram_wmask_pkg::word_t d0;
    sram_wmask_pkg::word_t d1;
    d0 = sram_wmask_pkg::word_t'({$urandom(), $urandom()});
    d1 = sram_wmask_pkg::word_t'({$urandom(), $urandom()});
    for (int n = 0; wr_rdy !== 4'hf; n++) begin
      if (n == 50) begin
        err_count++;
        summarize();
      end
      m.idle(1);
    end
    for (int g = 0; g < 4; g++) begin
      mem[g][a][0] = upd(g, mem[g][a][0], d0, s0);
      mem[g][a][1] = upd(g, mem[g][a][1], d1, s1);
    end
    m.write_burst(sram_wmask_pkg::addr_t'(a), d0, d1, s0, s1);
  endtask : wr

  task automatic rd(input int a);
    addr_q.push_back(a);
    m.read_burst(sram_wmask_pkg::addr_t'(a));
  endtask : rd

  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize

  // ********
  // read monitor
  // ********
  // reads seen at the design's inputs, delayed to the data cycle
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n)
      rd_pipe <= 2'h0;
    else
      rd_pipe <= {rd_pipe[0], ~ld_n & dir};
  end

  always @(negedge clock) begin
    if (rst_n) begin
      // outputs drive only in a read's data cycle
      check(oe, {4{rd_pipe[1]}});
      if (rd_pipe[1]) begin
        ra = addr_q.pop_front();
        for (int g = 0; g < 4; g++) begin
          ob = obits(g);
          // word A then A plus one, masked lanes kept
          check(rd_first[g] & ob, mem[g][ra][0] & ob);
          check(rd_second[g] & ob, mem[g][ra][1] & ob);
        end
      end
    end
  end

  // ********
  // main sequence
  // ********
  initial begin
    rst_n = 1'h0;
    err_count = 0;
    n_compared = 0;
    strap = 1'h1;
    void'($urandom(77159));
    repeat (12) @(posedge clock);
    #1;
    check(oe, 4'h0);
    check(wr_rdy, 4'hf);
    @(posedge clock);
    rst_n <= 1'h1;
    m.idle(2);
    #1;
    check(use_k, 4'hf);
    // fill, then lane corners, then random rounds; read all after each
    for (int r = 0; r < 4; r++) begin
      for (int i = 0; i < 24; i++) begin
        if (r == 0 && i < 16)
          wr(i, 4'h0, 4'h0);
        // no lane, single lanes and all lanes, a different mask on each beat
        else if (r == 1 && i < 6)
          wr(i, tbl[i], tbl[5 - i]);
        else if (r > 1)
          wr($urandom_range(15), 4'($urandom()), 4'($urandom()));
      end
      m.idle(8);
      for (int a = 0; a < 16; a++) rd(a);
      m.idle(4);
    end
    // second reset in mid-run, strap now low
    strap <= 1'h0;
    rst_n <= 1'h0;
    m.idle(2);
    #1;
    check(oe, 4'h0);
    check(use_k, 4'h0);
    @(posedge clock);
    rst_n <= 1'h1;
    m.idle(2);
    #1;
    check(use_k, 4'h0);
    check(oe, 4'h0);
    summarize();
  end
endmodule : tb
